/* core/amc_cfg.svh */
/*
 holds the constants of the auto/manual output block: register offsets, field
 positions, reset values, value ranges and key hold times.
 assumes a 100 MHz clock; values are signed tenths of a percent.
*/
`ifndef AMC_CFG_SVH
`define AMC_CFG_SVH

`define AMC_CLK_HZ 100000000
`define AMC_MODE_HOLD_MS 3000
`define AMC_BACK_HOLD_MS 1000
`define AMC_FKEY_HOLD_MS 1000

// register byte offsets
`define AMC_REG_CTRL 12'h000
`define AMC_REG_MANUAL 12'h004
`define AMC_REG_INIT 12'h008
`define AMC_REG_LIMITS 12'h00C
`define AMC_REG_STATUS 12'h010
`define AMC_REG_RAMP 12'h014

// control field positions
`define AMC_CTRL_METHOD 0
`define AMC_CTRL_LIMIT 1
`define AMC_CTRL_HEATCOOL 2
`define AMC_CTRL_FKEY_AM 3
`define AMC_CTRL_EVENT_AM 4
`define AMC_CTRL_PID 5
`define AMC_CTRL_COMMIT 8

// status field positions
`define AMC_ST_MANUAL 0
`define AMC_ST_TUNE_ABORT 1
`define AMC_ST_RAMPING 2
`define AMC_ST_DIRTY 3

// ranges and reset values, tenths of a percent except the control register reset value
`define AMC_MV_MIN_STD 16'hFFCE
`define AMC_MV_MIN_HC 16'hFBE6
`define AMC_MV_MAX 16'h041A
`define AMC_INIT_RESET 16'h0000
`define AMC_UPPER_RESET 16'h03E8
`define AMC_LOWER_RESET 16'h0000
`define AMC_RAMP_RESET 16'h0001
`define AMC_CTRL_RESET 8'h20

`endif

/* core/amc_pkg.sv */
/*
 holds the types of the auto/manual output block.
 assumes the constants header is included by the design file.
*/
package amc_pkg;
    typedef enum logic [1:0]
    {
        AMC_AUTO = 2'b00,
        AMC_MANUAL = 2'b01,
        AMC_BUMPLESS = 2'b10
    } amc_mode_t;

    typedef enum logic [1:0]
    {
        AMC_VIEW_OPERATION = 2'b00,
        AMC_VIEW_ADJUST = 2'b01,
        AMC_VIEW_AUTO_MANUAL = 2'b10,
        AMC_VIEW_MANUAL = 2'b11
    } amc_view_t;
endpackage : amc_pkg

/* core/amc_auto_manual.sv */
/*
 auto/manual output selection of a process controller with an apb register port.
 assumes a 100 MHz clock, synchronous inputs, and that the mv held in the
 retained register survives power loss in a backed-up supply domain outside.
*/
// Notes on behaviour
// - in manual mode the output is the manual value, changes apply at once
// - manual entry starts from last output or stored initial value per method
// - after power cycle in manual mode, resume with the retained manual value
// - with limit enable on, manual value clamps to lower and upper mv limits
// - return to auto starts from held output and ramps toward auto value
// - manual value accepts -5.0..105.0, or -105.0..105.0 for heating/cooling
// - initial value defaults 0.0; method defaults hold; limit enable defaults off
// - mode key held 3 s on auto/manual view enters manual and manual view
// - in manual mode only the manual view can be shown
// - mode key held 1 s on manual view returns to auto and operation view
// - assigned function key held 1 s in adjust or operation enters manual
// - manual value drives the output even while control is stopped
// - entering manual aborts any running auto-tuning
// - a running set-point ramp continues in manual mode
// - an assigned event input enters manual on its rising edge and returns to auto on its falling edge
// - automatic display return is suppressed in manual mode
// - manual mode is available when pid control is configured
// - key edits reach the output before they are committed to storage
`timescale 1ns/100ps
`include "amc_cfg.svh"

module amc_auto_manual #(
    parameter int MODE_HOLD_CYCLES = `AMC_CLK_HZ / 1000 * `AMC_MODE_HOLD_MS,
    parameter int BACK_HOLD_CYCLES = `AMC_CLK_HZ / 1000 * `AMC_BACK_HOLD_MS,
    parameter int FKEY_HOLD_CYCLES = `AMC_CLK_HZ / 1000 * `AMC_FKEY_HOLD_MS
)(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mode_key,
    input wire logic function_key,
    input wire logic up_key,
    input wire logic down_key,
    input wire logic event_input,
    input wire logic control_tick,
    input wire logic control_stopped,
    input wire logic [15:0] auto_mv,
    input wire logic [1:0] view_request,
    input wire logic tuning_active,
    input wire logic ramp_active,
    input wire logic [15:0] retained_mv,
    input wire logic retained_manual,
    output logic [15:0] mv_out,
    output logic manual_mode,
    output logic [1:0] view,
    output logic tune_abort,
    output logic ramp_continue,
    output logic display_return_enable,
    output logic store_request,
    output logic [15:0] store_mv
);
    amc_pkg::amc_mode_t mode_q;
    amc_pkg::amc_view_t view_q;
    logic [7:0] ctrl_q;
    logic [15:0] init_q;
    logic [15:0] upper_q;
    logic [15:0] lower_q;
    logic [15:0] ramp_q;
    logic [15:0] manual_q;
    logic [15:0] mv_q;
    logic dirty_q;
    logic boot_q;
    logic event_q;
    logic [31:0] mode_cnt_q;
    logic [31:0] fkey_cnt_q;
    logic mode_fired_q;
    logic fkey_fired_q;
    logic wr_en;
    logic enter_manual;
    logic leave_manual;
    logic is_manual;
    logic [15:0] entry_value;

    // clamp a signed value to a window
    function automatic logic [15:0] amc_clamp(input logic [15:0] v, input logic [15:0] lo,
                                              input logic [15:0] hi);
        if ($signed(v) < $signed(lo))
            amc_clamp = lo;
        else if ($signed(v) > $signed(hi))
            amc_clamp = hi;
        else
            amc_clamp = v;
    endfunction : amc_clamp

    // manual value range, then optional mv limits
    function automatic logic [15:0] amc_legal(input logic [15:0] v, input logic [7:0] c,
                                              input logic [15:0] lo, input logic [15:0] hi);
        logic [15:0] r;
        r = amc_clamp(v, c[`AMC_CTRL_HEATCOOL] ? `AMC_MV_MIN_HC : `AMC_MV_MIN_STD, `AMC_MV_MAX);
        if (c[`AMC_CTRL_LIMIT])
            r = amc_clamp(r, lo, hi);
        amc_legal = r;
    endfunction : amc_legal

    assign wr_en = clk_en && psel && penable && pwrite;
    assign is_manual = (mode_q == amc_pkg::AMC_MANUAL);

    // starting manual value by method
    assign entry_value = ctrl_q[`AMC_CTRL_METHOD] ? amc_legal(init_q, ctrl_q, lower_q, upper_q)
                                                  : amc_legal(mv_q, ctrl_q, lower_q, upper_q);

    // mode transitions from keys and event input
    always_comb
    begin
        enter_manual = 1'b0;
        leave_manual = 1'b0;
        if (ctrl_q[`AMC_CTRL_PID] && !is_manual)
        begin
            if (mode_cnt_q == 32'(MODE_HOLD_CYCLES - 1) && !mode_fired_q && view_q == amc_pkg::AMC_VIEW_AUTO_MANUAL)
                enter_manual = 1'b1;
            if (fkey_cnt_q == 32'(FKEY_HOLD_CYCLES - 1) && !fkey_fired_q && ctrl_q[`AMC_CTRL_FKEY_AM]
                && (view_q == amc_pkg::AMC_VIEW_OPERATION || view_q == amc_pkg::AMC_VIEW_ADJUST))
                enter_manual = 1'b1;
            if (ctrl_q[`AMC_CTRL_EVENT_AM] && event_input && !event_q)
                enter_manual = 1'b1;
        end
        if (is_manual)
        begin
            if (mode_cnt_q == 32'(BACK_HOLD_CYCLES - 1) && !mode_fired_q)
                leave_manual = 1'b1;
            if (ctrl_q[`AMC_CTRL_EVENT_AM] && !event_input && event_q)
                leave_manual = 1'b1;
        end
    end

    // key hold counters, one firing per press
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mode_cnt_q <= 32'h0000_0000;
            fkey_cnt_q <= 32'h0000_0000;
            mode_fired_q <= 1'b0;
            fkey_fired_q <= 1'b0;
            event_q <= 1'b0;
        end
        else if (clk_en)
        begin
            event_q <= event_input;
            if (!mode_key)
            begin
                mode_cnt_q <= 32'h0000_0000;
                mode_fired_q <= 1'b0;
            end
            else if (enter_manual || leave_manual)
                mode_fired_q <= 1'b1;
            else if (!mode_fired_q)
                mode_cnt_q <= mode_cnt_q + 32'h0000_0001;
            if (!function_key)
            begin
                fkey_cnt_q <= 32'h0000_0000;
                fkey_fired_q <= 1'b0;
            end
            else if (enter_manual)
                fkey_fired_q <= 1'b1;
            else if (!fkey_fired_q)
                fkey_cnt_q <= fkey_cnt_q + 32'h0000_0001;
        end
    end

    // mode state and manual value
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mode_q <= amc_pkg::AMC_AUTO;
            manual_q <= `AMC_INIT_RESET;
            boot_q <= 1'b1;
            dirty_q <= 1'b0;
        end
        else if (clk_en)
        begin
            boot_q <= 1'b0;
            if (boot_q)
            begin
                if (retained_manual)
                begin
                    mode_q <= amc_pkg::AMC_MANUAL;
                    manual_q <= retained_mv;
                end
            end
            else
            begin
                if (wr_en && paddr == `AMC_REG_CTRL && pwdata[`AMC_CTRL_COMMIT])
                    dirty_q <= 1'b0; // edits below win
                case (mode_q)
                    amc_pkg::AMC_AUTO, amc_pkg::AMC_BUMPLESS:
                    begin
                        if (enter_manual)
                        begin
                            mode_q <= amc_pkg::AMC_MANUAL;
                            manual_q <= entry_value;
                        end
                        else if (mode_q == amc_pkg::AMC_BUMPLESS && mv_q == auto_mv)
                            mode_q <= amc_pkg::AMC_AUTO;
                    end
                    amc_pkg::AMC_MANUAL:
                    begin
                        if (leave_manual)
                            mode_q <= amc_pkg::AMC_BUMPLESS;
                        else if (wr_en && paddr == `AMC_REG_MANUAL)
                        begin
                            manual_q <= amc_legal(pwdata[15:0], ctrl_q, lower_q, upper_q);
                            dirty_q <= 1'b1;
                        end
                        else if (up_key && !mode_key)
                        begin
                            manual_q <= amc_legal(manual_q + 16'h0001, ctrl_q, lower_q, upper_q);
                            dirty_q <= 1'b1;
                        end
                        else if (down_key && !mode_key)
                        begin
                            manual_q <= amc_legal(manual_q - 16'h0001, ctrl_q, lower_q, upper_q);
                            dirty_q <= 1'b1;
                        end
                        else
                            manual_q <= amc_legal(manual_q, ctrl_q, lower_q, upper_q);
                    end
                    default:
                        mode_q <= amc_pkg::AMC_AUTO;
                endcase
            end
        end
    end

    // output value: manual wins even when stopped, bumpless ramp on return
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mv_q <= `AMC_INIT_RESET;
        end
        else if (clk_en)
        begin
            if (is_manual)
                mv_q <= manual_q;
            else if (mode_q == amc_pkg::AMC_BUMPLESS)
            begin
                if (control_tick)
                begin
                    if ($signed(auto_mv) > $signed(mv_q) + $signed(ramp_q))
                        mv_q <= mv_q + ramp_q;
                    else if ($signed(auto_mv) < $signed(mv_q) - $signed(ramp_q))
                        mv_q <= mv_q - ramp_q;
                    else
                        mv_q <= auto_mv;
                end
            end
            else if (!control_stopped)
                mv_q <= auto_mv;
        end
    end

    // display level tracking
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            view_q <= amc_pkg::AMC_VIEW_OPERATION;
        else if (clk_en)
        begin
            if (enter_manual || (boot_q && retained_manual))
                view_q <= amc_pkg::AMC_VIEW_MANUAL;
            else if (leave_manual)
                view_q <= amc_pkg::AMC_VIEW_OPERATION;
            else if (!is_manual)
                view_q <= amc_pkg::amc_view_t'(view_request);
            else
                view_q <= amc_pkg::AMC_VIEW_MANUAL;
        end
    end

    // configuration registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctrl_q <= `AMC_CTRL_RESET;
            init_q <= `AMC_INIT_RESET;
            upper_q <= `AMC_UPPER_RESET;
            lower_q <= `AMC_LOWER_RESET;
            ramp_q <= `AMC_RAMP_RESET;
        end
        else if (wr_en)
        begin
            case (paddr)
                `AMC_REG_CTRL: ctrl_q <= pwdata[7:0];
                `AMC_REG_INIT: init_q <= amc_clamp(pwdata[15:0],
                    ctrl_q[`AMC_CTRL_HEATCOOL] ? `AMC_MV_MIN_HC : `AMC_MV_MIN_STD, `AMC_MV_MAX);
                `AMC_REG_LIMITS:
                begin
                    lower_q <= pwdata[15:0];
                    upper_q <= pwdata[31:16];
                end
                `AMC_REG_RAMP: ramp_q <= (pwdata[15:0] == 16'h0000) ? `AMC_RAMP_RESET : pwdata[15:0];
                default: ;
            endcase
        end
    end

    // apb read and answer
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (clk_en)
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !(paddr == `AMC_REG_CTRL || paddr == `AMC_REG_MANUAL
                || paddr == `AMC_REG_INIT || paddr == `AMC_REG_LIMITS || paddr == `AMC_REG_STATUS
                || paddr == `AMC_REG_RAMP);
            if (psel && !penable)
            begin
                case (paddr)
                    `AMC_REG_CTRL: prdata <= {24'h00_0000, ctrl_q};
                    `AMC_REG_MANUAL: prdata <= {16'h0000, manual_q};
                    `AMC_REG_INIT: prdata <= {16'h0000, init_q};
                    `AMC_REG_LIMITS: prdata <= {upper_q, lower_q};
                    `AMC_REG_STATUS: prdata <= {28'h000_0000, dirty_q, ramp_active && is_manual,
                                                tuning_active && is_manual, is_manual};
                    `AMC_REG_RAMP: prdata <= {16'h0000, ramp_q};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // outputs to the rest of the controller
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            mv_out <= `AMC_INIT_RESET;
            manual_mode <= 1'b0;
            view <= 2'b00;
            tune_abort <= 1'b0;
            ramp_continue <= 1'b0;
            display_return_enable <= 1'b1;
            store_request <= 1'b0;
            store_mv <= `AMC_INIT_RESET;
        end
        else if (clk_en)
        begin
            mv_out <= mv_q;
            manual_mode <= is_manual;
            view <= view_q;
            tune_abort <= is_manual && tuning_active;
            ramp_continue <= ramp_active;
            display_return_enable <= !is_manual;
            store_request <= wr_en && paddr == `AMC_REG_CTRL && pwdata[`AMC_CTRL_COMMIT] && dirty_q;
            store_mv <= manual_q;
        end
    end

    chk_manual_drives_out: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && is_manual && $past(clk_en) |=> mv_q == $past(manual_q))
        else $error("manual value not driven");
    chk_tune_abort_manual: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && is_manual && tuning_active |=> tune_abort || !clk_en)
        else $error("tuning not aborted");
    chk_return_disabled: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && is_manual |=> !display_return_enable || !clk_en)
        else $error("display return in manual");
    chk_manual_view_only: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && is_manual && !boot_q && !leave_manual |=> view_q == amc_pkg::AMC_VIEW_MANUAL || !clk_en)
        else $error("view left manual");
    chk_entry_on_key: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && enter_manual |=> mode_q == amc_pkg::AMC_MANUAL)
        else $error("entry missed");
    chk_leave_bumpless: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && leave_manual |=> mode_q == amc_pkg::AMC_BUMPLESS && mv_q == $past(mv_q))
        else $error("return not bumpless");
    chk_limit_clamp: assert property (@(posedge clk) disable iff (!rst_n)
        is_manual && ctrl_q[`AMC_CTRL_LIMIT] && $past(ctrl_q[`AMC_CTRL_LIMIT]) && !boot_q
        && $stable({manual_q, lower_q, upper_q}) && $signed(lower_q) <= $signed(upper_q)
        |-> $signed(manual_q) >= $signed(lower_q) && $signed(manual_q) <= $signed(upper_q))
        else $error("limit exceeded");
    chk_ramp_passes: assert property (@(posedge clk) disable iff (!rst_n)
        clk_en && ramp_active |=> ramp_continue || !clk_en)
        else $error("ramp dropped");
endmodule : amc_auto_manual

/* verification/amc_partner.sv */
/*
 control-loop side model: paces control cycles and offers the automatic mv.
 assumes one clock shared with the auto/manual block, sync active-low reset.
*/
`timescale 1ns/100ps

module amc_partner #(
    parameter int TICK_DIV = 4,
    parameter logic [15:0] AUTO_MV = 16'h0100
)(
    input wire logic clk,
    input wire logic rst_n,
    output logic control_tick,
    output logic [15:0] auto_mv,
    output logic tuning_active,
    output logic ramp_active
);
    int cnt_q;

    // one tick pulse every TICK_DIV cycles, loop always tuning and ramping
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt_q <= 0;
            control_tick <= 1'b0;
        end
        else
        begin
            cnt_q <= (cnt_q == TICK_DIV - 1) ? 0 : cnt_q + 1;
            control_tick <= (cnt_q == TICK_DIV - 1);
        end
    end

    assign auto_mv = AUTO_MV;
    assign tuning_active = 1'b1;
    assign ramp_active = 1'b1;
endmodule : amc_partner

/* verification/tb_amc_auto_manual.sv */
/*
 self-checking bench of the auto/manual block: apb master, key and event driver.
 assumes hold counts shortened to 20/10/10 cycles and a 100 MHz clock.
*/
`timescale 1ns/100ps
`include "amc_cfg.svh"

module tb_amc_auto_manual;
    localparam logic [15:0] AUTO = 16'h0100;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, mode_key, function_key, event_input;
    logic control_tick, tuning_active, ramp_active, control_stopped, retained_manual;
    logic clk_en, up_key, down_key;
    logic manual_mode, tune_abort, ramp_continue, display_return_enable, store_request;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] auto_mv, retained_mv, mv_out, store_mv;
    logic [1:0] view_request, view;
    logic er;
    int n_errors = 0;
    int checks = 0;
    typedef struct {logic [11:0] a; logic [31:0] d; logic e;} amc_row_t;
    amc_row_t rows[6] = '{'{`AMC_REG_CTRL, 32'h20, 0}, '{`AMC_REG_INIT, 32'h0, 0},
        '{`AMC_REG_LIMITS, 32'h03E80000, 0}, '{`AMC_REG_RAMP, 32'h1, 0},
        '{`AMC_REG_STATUS, 32'h0, 0}, '{12'h018, 32'h0, 1}};

    amc_auto_manual #(.MODE_HOLD_CYCLES(20), .BACK_HOLD_CYCLES(10), .FKEY_HOLD_CYCLES(10)) i_dut (
        .clk(clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mode_key(mode_key), .function_key(function_key), .up_key(up_key), .down_key(down_key),
        .event_input(event_input), .control_tick(control_tick), .control_stopped(control_stopped),
        .auto_mv(auto_mv), .view_request(view_request), .tuning_active(tuning_active),
        .ramp_active(ramp_active), .retained_mv(retained_mv), .retained_manual(retained_manual),
        .mv_out(mv_out), .manual_mode(manual_mode), .view(view), .tune_abort(tune_abort),
        .ramp_continue(ramp_continue), .display_return_enable(display_return_enable),
        .store_request(store_request), .store_mv(store_mv));

    amc_partner #(.TICK_DIV(4), .AUTO_MV(AUTO)) i_partner (.clk(clk), .rst_n(rst_n),
        .control_tick(control_tick), .auto_mv(auto_mv), .tuning_active(tuning_active),
        .ramp_active(ramp_active));

    // clock generation
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // compare and count
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // one apb transfer, waits for pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // hold a key for n + 2 cycles: 0 mode key, 1 function key
    task hold(input int sel, input int n);
        @(posedge clk);
        if (sel == 0) mode_key <= 1'b1;
        else function_key <= 1'b1;
        repeat (n + 2) @(posedge clk);
        mode_key <= 1'b0;
        function_key <= 1'b0;
    endtask : hold

    // bounded wait for an output value, then compare
    task wait_mv(input logic [15:0] exp, input int lim);
        int n;
        for (n = 0; n < lim && mv_out !== exp; n++) @(posedge clk);
        cmp(mv_out, exp);
    endtask : wait_mv

    task wait_mode(input logic exp);
        int n;
        for (n = 0; n < 40 && manual_mode !== exp; n++) @(posedge clk);
        cmp(manual_mode, exp);
    endtask : wait_mode

    task final_report;
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    // watchdog against hangs
    initial
    begin
        #500000;
        n_errors++;
        final_report();
    end

    // main sequence
    initial
    begin
        {rst_n, psel, penable, pwrite, mode_key, function_key, event_input} = '0;
        {paddr, pwdata, retained_mv, retained_manual, control_stopped} = '0;
        view_request = 2'd2;
        {clk_en, up_key, down_key} = 3'b100;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            apb(1'b0, rows[i].a, 32'h0);
            cmp(rd, rows[i].d);
            cmp(er, rows[i].e);
        end
        cmp(display_return_enable, 1'b1);
        cmp({tune_abort, ramp_continue}, 2'b01);
        wait_mv(AUTO, 40);
        $display("test registers done");
        // hold-method entry from the auto/manual view
        hold(0, 20);
        wait_mode(1'b1);
        repeat (2) @(posedge clk);
        cmp(mv_out, AUTO);
        cmp(view, 2'd3);
        cmp({tune_abort, ramp_continue, display_return_enable}, 3'b110);
        view_request <= 2'd0;
        repeat (3) @(posedge clk);
        cmp(view, 2'd3);
        control_stopped <= 1'b1;
        apb(1'b1, `AMC_REG_MANUAL, 32'h0300);
        wait_mv(16'h0300, 4);
        apb(1'b1, `AMC_REG_MANUAL, 32'hF000);
        wait_mv(`AMC_MV_MIN_STD, 4);
        apb(1'b1, `AMC_REG_LIMITS, 32'h02000050);
        apb(1'b1, `AMC_REG_CTRL, 32'h22);
        wait_mv(16'h0050, 6);
        apb(1'b1, `AMC_REG_MANUAL, 32'h0300);
        wait_mv(16'h0200, 4);
        control_stopped <= 1'b0;
        $display("test manual done");
        // bumpless return
        hold(0, 10);
        wait_mode(1'b0);
        cmp(view, 2'd0);
        cmp(mv_out == AUTO, 1'b0);
        wait_mv(AUTO, 3000);
        $display("test return done");
        // function key entry with the stored initial value
        apb(1'b1, `AMC_REG_INIT, 32'h0064);
        apb(1'b1, `AMC_REG_CTRL, 32'h29);
        hold(1, 10);
        wait_mode(1'b1);
        wait_mv(16'h0064, 4);
        // event input selects the mode
        apb(1'b1, `AMC_REG_CTRL, 32'h30);
        event_input <= 1'b1;
        repeat (3) @(posedge clk);
        event_input <= 1'b0;
        wait_mode(1'b0);
        event_input <= 1'b1;
        wait_mode(1'b1);
        $display("test keys and event done");
        // key edits, clock-enable freeze and commit in manual
        apb(1'b1, `AMC_REG_MANUAL, 32'h0200);
        wait_mv(16'h0200, 6);
        up_key <= 1'b1;
        repeat (3) @(posedge clk);
        up_key <= 1'b0;
        wait_mv(16'h0203, 6);
        down_key <= 1'b1;
        @(posedge clk);
        down_key <= 1'b0;
        wait_mv(16'h0202, 6);
        clk_en <= 1'b0;
        up_key <= 1'b1;
        repeat (4) @(posedge clk);
        cmp(mv_out, 16'h0202);
        up_key <= 1'b0;
        clk_en <= 1'b1;
        apb(1'b0, `AMC_REG_STATUS, 32'h0);
        cmp(rd, 32'h0000_000F);
        apb(1'b1, `AMC_REG_CTRL, 32'h0000_0130);
        @(posedge clk);
        cmp(store_request, 1'b1);
        cmp(store_mv, 16'h0202);
        @(posedge clk);
        cmp(store_request, 1'b0);
        apb(1'b0, `AMC_REG_STATUS, 32'h0);
        cmp(rd, 32'h0000_0007);
        $display("test edits and commit done");
        // power cycle while in manual
        retained_manual <= 1'b1;
        retained_mv <= 16'h0123;
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        event_input <= 1'b0;
        wait_mode(1'b1);
        wait_mv(16'h0123, 4);
        $display("test power cycle done");
        final_report();
    end
endmodule : tb_amc_auto_manual
